// >>> hdl/dpb_dev.sv
/*
  Device end: fetches parameter blocks, checks them, starts drive operations,
  follows chains, writes the wait bit back and raises completion interrupts.
  Assumes a host end that answers a memory read one cycle after it and a
  drive engine on mclk that pulses op_done with a status byte.
*/
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "dpb_regs.svh"
module dpb_dev #(
  parameter int unsigned WAIT_CYC = `DPB_WAIT_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  dpb_if.dev lnk,
  input wire logic [1:0] drive_ready,
  input wire logic op_done,
  input wire dpb_pkg::dpb_byte_t op_status,
  output logic op_start,
  output logic [2:0] op_code,
  output logic op_unit,
  output dpb_pkg::dpb_byte_t op_track,
  output logic [4:0] op_sector,
  output dpb_pkg::dpb_byte_t op_count,
  output dpb_pkg::dpb_addr_t op_buf,
  output logic op_fmt_random
);
  import dpb_pkg::*;
  typedef struct packed {
    dpb_state_e st;
    dpb_addr_t base;
    logic [3:0] idx;
    logic [9:0][7:0] blk;
    dpb_byte_t result;
    logic [5:0] tag;
    logic irq;
    logic busy;
    logic [1:0] rdy_a;
    logic [1:0] rdy_b;
    logic [1:0] rdy_c;
    logic [2:0] rdy_arm;
    logic mem_rd;
    logic mem_wr;
    dpb_addr_t mem_addr;
    dpb_byte_t mem_wdata;
    logic op_start;
    logic wait_en;
  } dpb_dev_s;
  dpb_dev_s r, n;
  logic tick;
  logic [7:0] ctrl;
  logic [1:0] icode;
  dpb_addr_t next_ptr;

  // Disk address check of a fetched block.
  function automatic logic addr_bad(input logic [9:0][7:0] b);
    logic [2:0] op;
    logic [8:0] last;
    logic xfer;
    op = b[`DPB_B_INSTR][`DPB_I_OP_HI:0];
    last = {4'h0, b[`DPB_B_SECTOR][`DPB_S_SEC_HI:0]} + {1'b0, b[`DPB_B_COUNT]};
    xfer = op[2];
    addr_bad = 1'b0;
    if (op != 3'b000 && op != 3'b011 && b[`DPB_B_TRACK] > `DPB_MAX_TRACK)
      addr_bad = 1'b1; // RULE_16
    if (xfer && (b[`DPB_B_SECTOR][`DPB_S_SEC_HI:0] == 5'h00 ||
        {3'h0, b[`DPB_B_SECTOR][`DPB_S_SEC_HI:0]} > `DPB_MAX_SECTOR))
      addr_bad = 1'b1; // RULE_17
    if (xfer && last > {1'b0, `DPB_MAX_SECTOR})
      addr_bad = 1'b1; // RULE_15
    if (b[`DPB_B_SECTOR][`DPB_S_UNIT] != b[`DPB_B_INSTR][`DPB_I_UNIT])
      addr_bad = 1'b1; // RULE_17
  endfunction

  // Completion interrupt policy from the interrupt control code.
  function automatic logic irq_wanted(input logic [1:0] ic, input logic succ,
                                      input logic err);
    unique case (ic)
      `DPB_IC_END: irq_wanted = !succ || err; // RULE_03 RULE_07
      `DPB_IC_NONE: irq_wanted = 1'b0; // RULE_04
      `DPB_IC_FORCE: irq_wanted = 1'b1; // RULE_04
      `DPB_IC_BAD: irq_wanted = 1'b1;
    endcase
  endfunction

  dpb_tick #(
    .CYC(WAIT_CYC)
  ) u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .en(r.wait_en),
    .tick(tick)
  );

  // Fields of the block in hand.
  assign ctrl = r.blk[`DPB_B_CTRL];
  assign icode = ctrl[`DPB_C_IC_HI:`DPB_C_IC_LO];
  assign next_ptr = {r.blk[`DPB_B_NXTHI], r.blk[`DPB_B_NXTLO]}; // RULE_20 RULE_21

  // Sequencer: fetch, decide, run, write back, interrupt, chain.
  always_comb
  begin
    n = r;
    n.op_start = 1'b0;
    n.mem_rd = 1'b0;
    n.mem_wr = 1'b0;
    n.wait_en = 1'b0;
    n.rdy_a = drive_ready;
    n.rdy_b = r.rdy_a;
    n.rdy_c = r.rdy_b;
    // The change detector arms once all three stages hold pin levels, so a drive
    // that is ready at reset raises no false interrupt; a change after the level
    // first sampled after reset is still reported.
    n.rdy_arm = {r.rdy_arm[1:0], 1'b1};
    if (lnk.irq_ack)
      n.irq = 1'b0;
    if (r.rdy_arm[2] && r.rdy_c != r.rdy_b)
      n.irq = 1'b1; // RULE_05
    unique case (r.st)
      DPB_IDLE:
      begin
        if (lnk.ptr_load)
        begin
          n.base = lnk.ptr; // RULE_01
          n.idx = 4'h0;
          n.busy = 1'b1;
          n.result = `DPB_RST_BYTE;
          n.st = DPB_FETCH;
        end
      end
      DPB_FETCH:
      begin
        n.mem_rd = 1'b1;
        n.mem_addr = r.base + {12'h000, r.idx}; // RULE_23
        n.st = DPB_RDW;
      end
      DPB_RDW:
        n.st = DPB_GETB;
      DPB_GETB:
      begin
        n.blk[r.idx] = lnk.mem_rdata; // RULE_01
        if (r.idx == `DPB_B_NXTHI)
          n.st = DPB_DECIDE;
        else
        begin
          n.idx = r.idx + 4'h1; // RULE_23
          n.st = DPB_FETCH;
        end
      end
      DPB_DECIDE:
      begin
        n.tag = r.blk[`DPB_B_TAG][`DPB_TAG_HI:0];
        if (!ctrl[`DPB_C_WAIT])
        begin
          if (icode == `DPB_IC_BAD || addr_bad(r.blk))
          begin
            n.result[`DPB_R_ADDR] = 1'b1; // RULE_22 RULE_24
            n.st = DPB_FINISH;
          end
          else
          begin
            n.op_start = 1'b1; // RULE_08
            n.st = DPB_RUN;
          end
        end
        else if (ctrl[`DPB_C_BOW])
        begin
          n.base = next_ptr; // RULE_09
          n.idx = 4'h0;
          n.st = DPB_FETCH;
        end
        else
          n.st = DPB_PAUSE;
      end
      DPB_PAUSE:
      begin
        n.wait_en = 1'b1;
        if (tick)
        begin
          n.idx = 4'h0; // RULE_10
          n.st = DPB_FETCH;
        end
      end
      DPB_RUN:
      begin
        if (op_done)
        begin
          n.result = op_status;
          n.st = DPB_FINISH;
        end
      end
      DPB_FINISH:
      begin
        if (!ctrl[`DPB_C_LOCK])
        begin
          n.mem_wr = 1'b1; // RULE_12
          n.mem_addr = r.base;
          n.mem_wdata = ctrl | 8'h01;
        end
        n.st = DPB_ENDOP;
      end
      DPB_ENDOP:
      begin
        if (irq_wanted(icode, ctrl[`DPB_C_SUCC], r.result != 8'h00))
          n.irq = 1'b1;
        if (ctrl[`DPB_C_SUCC] && r.result == 8'h00)
        begin
          n.base = next_ptr; // RULE_07 RULE_21
          n.idx = 4'h0;
          n.st = DPB_FETCH;
        end
        else
        begin
          n.busy = 1'b0;
          n.st = DPB_IDLE;
        end
      end
      default:
        n.st = DPB_IDLE;
    endcase
  end

  // Registers the whole device state.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= n;
  end

  // Link outputs.
  assign lnk.mem_rd = r.mem_rd;
  assign lnk.mem_wr = r.mem_wr;
  assign lnk.mem_addr = r.mem_addr;
  assign lnk.mem_wdata = r.mem_wdata;
  assign lnk.irq = r.irq;
  assign lnk.busy = r.busy;
  assign lnk.result = r.result;
  assign lnk.tag = r.tag;

  // Drive side outputs: the registered start strobe and fields straight from the held block.
  assign op_start = r.op_start;
  assign op_code = r.blk[`DPB_B_INSTR][`DPB_I_OP_HI:0]; // RULE_14
  assign op_unit = r.blk[`DPB_B_INSTR][`DPB_I_UNIT]; // RULE_13
  assign op_track = r.blk[`DPB_B_TRACK];
  assign op_sector = r.blk[`DPB_B_SECTOR][`DPB_S_SEC_HI:0];
  assign op_count = r.blk[`DPB_B_COUNT];
  assign op_buf = {r.blk[`DPB_B_BUFHI], r.blk[`DPB_B_BUFLO]}; // RULE_18
  assign op_fmt_random = ctrl[`DPB_C_FMT]; // RULE_02
endmodule // dpb_dev

// >>> hdl/dpb_host.sv
/*
  Host end: software register port, shared byte memory that the device
  reads and writes, pointer load and interrupt acknowledge.
  Assumes a software master on mclk with one-cycle strobes.
*/
`timescale 1ns/1ps
`include "dpb_regs.svh"
module dpb_host #(
  parameter int unsigned DEPTH = 256
) (
  input wire logic mclk,
  input wire logic rstn,
  dpb_if.host lnk,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq_out
);
  import dpb_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    dpb_addr_t ptr;
    logic ptr_load;
    logic irq_ack;
    dpb_byte_t mem_rdata;
    dpb_addr_t maddr;
    logic [31:0] rdata;
    logic irq;
  } dpb_host_s;
  dpb_host_s r, n;
  if (DEPTH < 16 || DEPTH > 65536 || (1 << AW) != DEPTH) begin : g_bad
    $error("Memory depth must be a power of two from 16 to 65536.");
  end

  // Memory index from a byte address; upper bits wrap.
  function automatic logic [AW-1:0] idx(input dpb_addr_t a);
    idx = a[AW-1:0];
  endfunction

  // Register port, memory service and link strobes.
  always_comb
  begin
    n = r;
    n.ptr_load = 1'b0;
    n.irq_ack = 1'b0;
    n.rdata = 32'h0000_0000;
    n.irq = lnk.irq;
    if (lnk.mem_rd)
      n.mem_rdata = r.mem[idx(lnk.mem_addr)];
    if (wr)
    begin
      unique case (addr)
        `DPB_REG_PTR:
        begin
          if (!lnk.busy)
          begin
            n.ptr = wdata[15:0]; // RULE_01
            n.ptr_load = 1'b1;
          end
        end
        `DPB_REG_STAT:
          n.irq_ack = wdata[0];
        `DPB_REG_MADDR:
          n.maddr = wdata[15:0];
        `DPB_REG_MDATA:
        begin
          n.mem[idx(r.maddr)] = wdata[7:0];
          n.maddr = r.maddr + 16'h0001;
        end
        default:
          n.maddr = r.maddr;
      endcase
    end
    if (rd)
    begin
      unique case (addr)
        `DPB_REG_PTR: n.rdata = {16'h0000, r.ptr};
        `DPB_REG_STAT: n.rdata = {30'h0, lnk.busy, lnk.irq};
        `DPB_REG_RESULT: n.rdata = {24'h0, lnk.result};
        `DPB_REG_TAG: n.rdata = {26'h0, lnk.tag}; // RULE_19
        `DPB_REG_MADDR: n.rdata = {16'h0000, r.maddr};
        `DPB_REG_MDATA:
        begin
          n.rdata = {24'h0, r.mem[idx(r.maddr)]};
          n.maddr = r.maddr + 16'h0001;
        end
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    // Device write-back lands last so it wins a same-address clash.
    if (lnk.mem_wr)
      n.mem[idx(lnk.mem_addr)] = lnk.mem_wdata; // RULE_12
  end

  // Registers the whole host state.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.ptr <= `DPB_RST_ADDR;
    end
    else
      r <= n;
  end

  assign lnk.ptr = r.ptr;
  assign lnk.ptr_load = r.ptr_load;
  assign lnk.irq_ack = r.irq_ack;
  assign lnk.mem_rdata = r.mem_rdata;
  assign rdata = r.rdata;
  assign irq_out = r.irq;
endmodule // dpb_host

// >>> hdl/dpb_tick.sv
/*
  Pause timer: one-cycle tick after CYC enabled cycles, restarts when idle.
  Assumes en is driven from logic on mclk.
*/
`timescale 1ns/1ps
`include "dpb_regs.svh"
module dpb_tick #(
  parameter int unsigned CYC = `DPB_WAIT_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic en,
  output logic tick
);
  import dpb_pkg::*;
  localparam int unsigned CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } dpb_tick_s;
  dpb_tick_s r, n;
  if (CYC < 1) begin : g_bad
    $error("Pause count must be at least one cycle.");
  end
  // Counts enabled cycles and pulses at the last one.
  always_comb
  begin
    n = r;
    n.tick = 1'b0;
    if (!en)
      n.cnt = '0;
    else if (r.cnt == LAST)
    begin
      n.cnt = '0;
      n.tick = 1'b1;
    end
    else
      n.cnt = r.cnt + 1'b1;
  end
  // Registers the timer state.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      r <= '0;
    else
      r <= n;
  end
  assign tick = r.tick;
endmodule // dpb_tick

// >>> include/dpb_if.sv
/*
  Link between the host end (pointer, memory, interrupt) and the device end.
  Assumes both ends run on the same mclk.
*/
`timescale 1ns/1ps
interface dpb_if;
  logic ptr_load;
  dpb_pkg::dpb_addr_t ptr;
  logic irq_ack;
  logic mem_rd;
  logic mem_wr;
  dpb_pkg::dpb_addr_t mem_addr;
  dpb_pkg::dpb_byte_t mem_wdata;
  dpb_pkg::dpb_byte_t mem_rdata;
  logic irq;
  logic busy;
  dpb_pkg::dpb_byte_t result;
  logic [5:0] tag;
  modport dev (
    input ptr_load, ptr, irq_ack, mem_rdata,
    output mem_rd, mem_wr, mem_addr, mem_wdata, irq, busy, result, tag
  );
  modport host (
    output ptr_load, ptr, irq_ack, mem_rdata,
    input mem_rd, mem_wr, mem_addr, mem_wdata, irq, busy, result, tag
  );
endinterface // dpb_if

// >>> include/dpb_pkg.sv
/*
  Types shared by both ends of the parameter block sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dpb_pkg;
  typedef logic [15:0] dpb_addr_t;
  typedef logic [7:0] dpb_byte_t;
  typedef enum logic [3:0] {
    DPB_IDLE = 4'b0000,
    DPB_FETCH = 4'b0001,
    DPB_RDW = 4'b0010,
    DPB_GETB = 4'b0011,
    DPB_DECIDE = 4'b0100,
    DPB_PAUSE = 4'b0101,
    DPB_RUN = 4'b0110,
    DPB_FINISH = 4'b0111,
    DPB_ENDOP = 4'b1000
  } dpb_state_e;
endpackage

// >>> include/dpb_regs.svh
/*
  Constants of the parameter block sequencer: block byte offsets, field
  positions, limits, result bits, host register offsets and timing.
  Assumes an includer that uses these as plain numbers of the stated widths.
*/
// Function
// RULE_01: Host pointer starts ten-byte block fetch.
// RULE_02: Control bit 6 picks format sector numbering.
// RULE_03: Code 00 interrupts at end or error.
// RULE_04: 01 none, 10 forced, 11 illegal.
// RULE_05: Ready changes always interrupt.
// RULE_06: Host sets matching word length bits.
// RULE_07: Bit 2 clear is last, else chain.
// RULE_08: Wait clear starts operation at once.
// RULE_09: Wait and branch jump to next block.
// RULE_10: Wait alone pauses 10 ms, rereads.
// RULE_11: Host keeps branch clear when wait clear.
// RULE_12: Write wait bit back unless lock set.
// RULE_13: Instruction bits 5:4 select the drive; the code decodes bit 5 only.
// RULE_14: Three-bit opcode selects the operation.
// RULE_15: Sector plus count above 26 errs.
// RULE_16: Track must be 0 to 76.
// RULE_17: Sector 1 to 26, bit 5 matches unit.
// RULE_18: Bytes 6 and 7 give buffer pointer.
// RULE_19: Host puts 6-bit tag in byte 8.
// RULE_20: Byte 9 is next pointer low half.
// RULE_21: Byte 10 is next pointer high half.
// RULE_22: Address errors set result bit 3.
// RULE_23: Fetch bytes ascending before drive activity.
// RULE_24: Interrupt code 11 is a parameter error.
`ifndef DPB_REGS_SVH
`define DPB_REGS_SVH
// Byte offsets inside a parameter block.
`define DPB_B_CTRL 4'd0
`define DPB_B_INSTR 4'd1
`define DPB_B_COUNT 4'd2
`define DPB_B_TRACK 4'd3
`define DPB_B_SECTOR 4'd4
`define DPB_B_BUFLO 4'd5
`define DPB_B_BUFHI 4'd6
`define DPB_B_TAG 4'd7
`define DPB_B_NXTLO 4'd8
`define DPB_B_NXTHI 4'd9
// Field positions of control, instruction and sector bytes.
`define DPB_C_WAIT 0
`define DPB_C_BOW 1
`define DPB_C_SUCC 2
`define DPB_C_IC_LO 4
`define DPB_C_IC_HI 5
`define DPB_C_FMT 6
`define DPB_C_LOCK 7
`define DPB_I_OP_HI 2
`define DPB_I_UNIT 5
`define DPB_S_SEC_HI 4
`define DPB_S_UNIT 5
`define DPB_TAG_HI 5
// Interrupt control codes.
`define DPB_IC_END 2'b00
`define DPB_IC_NONE 2'b01
`define DPB_IC_FORCE 2'b10
`define DPB_IC_BAD 2'b11
// Disk address limits.
`define DPB_MAX_TRACK 8'h4c
`define DPB_MAX_SECTOR 8'h1a
// Result byte bits.
`define DPB_R_ADDR 3
// Host register offsets and reset values.
`define DPB_REG_PTR 8'h00
`define DPB_REG_STAT 8'h04
`define DPB_REG_RESULT 8'h08
`define DPB_REG_TAG 8'h0c
`define DPB_REG_MADDR 8'h10
`define DPB_REG_MDATA 8'h14
`define DPB_RST_BYTE 8'h00
`define DPB_RST_ADDR 16'h0000
// Timing: poll pause in ms, clock in MHz, cycles derived from both.
`define DPB_WAIT_MS 10
`define DPB_CLK_MHZ 100
`define DPB_WAIT_CYC (`DPB_WAIT_MS * 1000 * `DPB_CLK_MHZ)
`endif

// >>> verif/diskette_param_block_sequencer_bench.sv
/*
  Self-checking bench: host end and device end joined by the link.
  Assumes a stand-in drive engine that finishes three cycles after a start.
*/
`timescale 1ns/1ps
`include "dpb_regs.svh"
module diskette_param_block_sequencer_bench;
  import dpb_pkg::*;
  logic mclk, rstn, wr, rd, op_start, op_unit, op_fmt_random, irq_out, u;
  logic op_done = 1'b0;
  logic [1:0] eng = 2'd0;
  logic [1:0] drive_ready;
  logic [2:0] op_code;
  logic [4:0] op_sector;
  logic [7:0] addr, c;
  logic [31:0] wdata, rdata, v;
  dpb_byte_t op_status, op_track, op_count;
  dpb_addr_t op_buf;
  int n_fail, cmp_count, n_start;
  dpb_if lnk ();
  dpb_host dpb_host_i (.mclk(mclk), .rstn(rstn), .lnk(lnk), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq_out(irq_out));
  dpb_dev #(.WAIT_CYC(20)) dpb_dev_i (.mclk(mclk), .rstn(rstn), .lnk(lnk),
    .drive_ready(drive_ready), .op_done(op_done), .op_status(op_status),
    .op_start(op_start), .op_code(op_code), .op_unit(op_unit), .op_track(op_track),
    .op_sector(op_sector), .op_count(op_count), .op_buf(op_buf),
    .op_fmt_random(op_fmt_random));
  dpb_seq_properties dpb_seq_properties_i (.mclk(mclk), .rstn(rstn),
    .ptr_load(lnk.ptr_load), .ptr(lnk.ptr), .irq_ack(lnk.irq_ack), .mem_rd(lnk.mem_rd),
    .mem_wr(lnk.mem_wr), .mem_addr(lnk.mem_addr), .mem_wdata(lnk.mem_wdata),
    .mem_rdata(lnk.mem_rdata), .irq(lnk.irq), .busy(lnk.busy), .result(lnk.result),
    .tag(lnk.tag));
  // Clock of 10 ns period.
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Drive engine stand-in: counts starts and answers each after three cycles.
  always @(posedge mclk)
  begin
    eng <= (op_start === 1'b1) ? 2'd3 : ((eng != 2'd0) ? eng - 2'd1 : 2'd0);
    op_done <= (eng == 2'd1);
    if (op_start === 1'b1)
      n_start <= n_start + 1;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask
  // Writes a ten-byte block into shared memory through the window registers.
  task automatic put(input logic [15:0] a, input logic [79:0] blk);
    wreg(`DPB_REG_MADDR, {16'h0, a});
    for (int i = 0; i < 10; i++)
      wreg(`DPB_REG_MDATA, {24'h0, blk[79-8*i -: 8]});
  endtask
  task automatic go(input logic [15:0] a);
    int k;
    wreg(`DPB_REG_PTR, {16'h0, a});
    repeat (4) @(negedge mclk);
    for (k = 0; k < 3000 && lnk.busy !== 1'b0; k++)
      @(negedge mclk);
    chk("busy", lnk.busy, 16'h0);
  endtask
  // Address or parameter error expected for one block.
  function automatic logic exp_err(input logic [7:0] c, i, n, t, s);
    exp_err = (c[5:4] == 2'b11) || (s[5] != i[5])
      || (t > 8'd76 && i[2:0] != 3'd0 && i[2:0] != 3'd3)
      || (i[2] && (s[4:0] == 5'd0 || s[4:0] > 5'd26 || {3'h0, s[4:0]} + n > 8'd26));
  endfunction
  task automatic one(input logic [7:0] c, i, n, t, s);
    logic [15:0] b;
    logic e;
    int s0;
    b = 16'($urandom);
    e = exp_err(c, i, n, t, s);
    s0 = n_start;
    wreg(`DPB_REG_STAT, 32'h1);
    put(16'h20, {c, i, n, t, s, b[7:0], b[15:8], 8'h15, 16'h0});
    go(16'h20);
    chk("starts", 16'(n_start - s0), {15'h0, !e});
    chk("addr_err", lnk.result[3], e);
    chk("tag", lnk.tag, 6'h15);
    if (!e)
    begin
      chk("op", {op_unit, op_code}, {i[5], i[2:0]});
      chk("fmt", op_fmt_random, c[6]);
      chk("track", {op_track, op_count}, {t, n});
      chk("sector", op_sector, s[4:0]);
      chk("buffer", op_buf, b);
    end
    wreg(`DPB_REG_MADDR, 32'h20);
    rreg(`DPB_REG_MDATA, v);
    chk("ctrl", v[7:0], c | {7'h0, !c[7]});
    chk("irq", {lnk.irq, irq_out}, {2{c[5:4] != 2'b01}});
  endtask
  initial
  begin
    #200000;
    n_fail++;
    test_done();
  end
  // Main sequence: reset, corner blocks, random blocks, chain, wait, ready.
  initial
  begin
    {rstn, wr, rd, addr, wdata, drive_ready, op_status} = '0;
    void'($urandom(32'h55ea));
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    one(8'h00, 8'h04, 8'd1, 8'd76, 8'd25);
    one(8'h30, 8'h04, 8'd2, 8'd77, 8'd25);
    one(8'ha8, 8'h3c, 8'd26, 8'd0, 8'h21);
    for (int j = 0; j < 24; j++)
    begin
      u = 1'($urandom_range(1));
      c = 8'($urandom) & 8'hf8;
      one(c, {2'b0, u, u, c[3], 3'(j)}, 8'($urandom_range(30)), 8'($urandom_range(80)),
        {2'b0, (j % 7 == 0) ? ~u : u, 5'($urandom_range(27))});
    end
    $display("single blocks done");
    v = n_start;
    wreg(`DPB_REG_STAT, 32'h1);
    put(16'h40, {8'h03, 8'h01, 8'h00, 8'h05, 8'h01, 16'h0, 8'h01, 16'h6000});
    // Middle link forces an interrupt, the last one suppresses its own.
    put(16'h60, {8'h24, 8'h01, 8'h00, 8'h05, 8'h01, 16'h0, 8'h02, 16'h8000});
    put(16'h80, {8'h10, 8'h01, 8'h00, 8'h09, 8'h01, 16'h0, 8'h03, 16'h0});
    go(16'h40);
    chk("chain_starts", 16'(n_start - v), 16'h2);
    chk("chain_last", {op_track, 2'b0, lnk.tag}, {8'h09, 8'h03});
    chk("chain_irq", lnk.irq, 16'h1);
    $display("chain done");
    // An address error, then a drive error, stop a chain and interrupt.
    @(posedge mclk);
    op_status <= 8'h04;
    v = n_start;
    put(16'hc0, {8'h04, 8'h01, 8'h00, 8'h4d, 8'h01, 16'h0, 8'h06, 16'h6000});
    put(16'he0, {8'h04, 8'h01, 8'h00, 8'h05, 8'h01, 16'h0, 8'h07, 16'h6000});
    for (int j = 0; j < 2; j++)
    begin
      wreg(`DPB_REG_STAT, 32'h1);
      go(j ? 16'he0 : 16'hc0);
      chk("err_stop", 16'(n_start - v), 16'(j));
      chk("err_irq", lnk.irq, 1'b1);
      chk("err_res", {lnk.result, 2'b0, lnk.tag}, {8'(j ? 4 : 8), 8'(6 + j)});
    end
    @(posedge mclk);
    op_status <= 8'h00;
    $display("error chain done");
    v = n_start;
    put(16'ha0, {8'h01, 8'h01, 8'h00, 8'h03, 8'h01, 16'h0, 8'h04, 16'h0});
    wreg(`DPB_REG_PTR, 32'ha0);
    repeat (80) @(negedge mclk);
    chk("held", {16'(n_start - v), lnk.busy}, {16'h0, 1'b1});
    put(16'ha0, {8'h00, 72'h0});
    go(16'ha0);
    chk("released", 16'(n_start - v), 16'h1);
    $display("wait done");
    wreg(`DPB_REG_STAT, 32'h1);
    @(posedge mclk);
    drive_ready <= 2'b10;
    repeat (6) @(negedge mclk);
    rreg(`DPB_REG_STAT, v);
    chk("ready_irq", v[1:0], 16'h1);
    rreg(8'h3c, v);
    chk("unmapped", v[15:0], 16'h0);
    $display("ready done");
    test_done();
  end
endmodule // diskette_param_block_sequencer_bench

// >>> verif/dpb_seq_properties.sv
/*
  Checker of the link that joins the host end and the device end.
  Assumes it is instantiated beside that link and fed its signals by name.
*/
`timescale 1ns/1ps
module dpb_seq_properties (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ptr_load,
  input wire dpb_pkg::dpb_addr_t ptr,
  input wire logic irq_ack,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire dpb_pkg::dpb_addr_t mem_addr,
  input wire dpb_pkg::dpb_byte_t mem_wdata,
  input wire dpb_pkg::dpb_byte_t mem_rdata,
  input wire logic irq,
  input wire logic busy,
  input wire dpb_pkg::dpb_byte_t result,
  input wire logic [5:0] tag
);
  import dpb_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // A load turns busy on, then the first read goes to the loaded pointer.
  sequence s_first_rd;
    busy ##1 (mem_rd && mem_addr == ptr);
  endsequence
  sequence s_rd_gap;
    !mem_rd [*2];
  endsequence
  property p_fetch_start;
    ptr_load && !busy |=> s_first_rd;
  endproperty
  property p_rd_gap;
    mem_rd |=> s_rd_gap;
  endproperty
  property p_rd_step;
    mem_rd ##3 (mem_rd && busy) |-> mem_addr == $past(mem_addr, 3) + 16'h0001;
  endproperty
  property p_wr_wait;
    mem_wr |-> mem_wdata[0] && busy;
  endproperty
  property p_rd_busy;
    mem_rd |-> busy && !mem_wr;
  endproperty
  property p_irq_hold;
    irq && !irq_ack |=> irq;
  endproperty
  property p_busy_cause;
    $rose(busy) |-> $past(ptr_load);
  endproperty
  property p_result_hold;
    !busy && !ptr_load |=> busy || ($stable(result) && $stable(tag));
  endproperty
  property p_rdata_hold;
    !mem_rd |=> $stable(mem_rdata);
  endproperty
  // Each label carries the name of the property that it asserts.
  a_fetch_start: assert property (p_fetch_start)
    else $error("fetch did not start at the loaded pointer");
  a_rd_gap: assert property (p_rd_gap)
    else $error("block reads closer than three cycles");
  a_rd_step: assert property (p_rd_step)
    else $error("block bytes not read in ascending order");
  a_wr_wait: assert property (p_wr_wait)
    else $error("write back without the wait bit");
  a_rd_busy: assert property (p_rd_busy)
    else $error("memory read outside a sequence");
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped before acknowledge");
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without a pointer load");
  a_result_hold: assert property (p_result_hold)
    else $error("result changed while idle");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
endmodule // dpb_seq_properties
